// [pmc_pkg.sv]
// constants and register map of the per-link performance monitor counter bank
//
// What this block does
// R1 - all mapping registers of the link refresh together in one cycle
// R2 - a zero-to-one write of the update trigger bit loads every mapping register
// R3 - with auto update enabled, every one-second tick loads every mapping register
// R4 - ten-bit CRC-6 error count in extended superframe; low byte 00H, top bits 01H
// R5 - twelve-bit F bit error count in SF, DM and SLC-96; 02H and 03H[3:0]
// R6 - in extended superframe the same counter counts frame alignment bit errors
// R7 - three-bit alignment change count at 04H bits 4 to 2
// R8 - five-bit sync loss count at 05H bits 4 to 0 in all four formats
// R9 - sixteen-bit pattern receiver bit error count; low 06H, high 07H
// R10 - sixteen-bit line code violation count; low 08H, high 09H
// R11 - ten-bit DDS pattern error count in DM format; low 0AH, top bits 0BH
// R12 - update copies accumulators and restarts them in the same cycle, losing nothing
// R13 - mapping registers are read-only; writes do nothing, reserved bits read zero
package pmc_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] PMC_IDX_CRC_LO  = 4'h0;
  localparam logic [3:0] PMC_IDX_CRC_HI  = 4'h1;
  localparam logic [3:0] PMC_IDX_FER_LO  = 4'h2;
  localparam logic [3:0] PMC_IDX_FER_HI  = 4'h3;
  localparam logic [3:0] PMC_IDX_ALIGN   = 4'h4;
  localparam logic [3:0] PMC_IDX_SYNC    = 4'h5;
  localparam logic [3:0] PMC_IDX_PAT_LO  = 4'h6;
  localparam logic [3:0] PMC_IDX_PAT_HI  = 4'h7;
  localparam logic [3:0] PMC_IDX_LCV_LO  = 4'h8;
  localparam logic [3:0] PMC_IDX_LCV_HI  = 4'h9;
  localparam logic [3:0] PMC_IDX_DDS_LO  = 4'hA;
  localparam logic [3:0] PMC_IDX_DDS_HI  = 4'hB;
  localparam logic [3:0] PMC_IDX_CTRL    = 4'hC;

  // counter widths
  localparam int PMC_W_CRC   = 10;
  localparam int PMC_W_FER   = 12;
  localparam int PMC_W_ALIGN = 3;
  localparam int PMC_W_SYNC  = 5;
  localparam int PMC_W_PAT   = 16;
  localparam int PMC_W_LCV   = 16;
  localparam int PMC_W_DDS   = 10;

  // field positions
  localparam int PMC_ALIGN_LSB  = 2;
  localparam int PMC_CTRL_AUTO  = 0;
  localparam int PMC_CTRL_TRIG  = 1;
  localparam int PMC_CTRL_FMT_L = 2;
  localparam int PMC_CTRL_FMT_H = 3;
  localparam int PMC_CTRL_W     = 4;

  localparam logic [PMC_CTRL_W-1:0] PMC_CTRL_RESET = 4'h0;

  // frame formats
  typedef enum logic [1:0] {
    PMC_FMT_SF    = 2'h0,
    PMC_FMT_ESF   = 2'h1,
    PMC_FMT_DM    = 2'h2,
    PMC_FMT_SLC96 = 2'h3
  } pmc_format_t;

endpackage

// [pmc_event_counter.sv]
// one saturating event accumulator with its snapshot register
`timescale 1ns/1ps
`default_nettype none
module pmc_event_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // event and group load
  input  wire logic         event_in,
  input  wire logic         load,
  // snapshot
  output logic [W-1:0]      snapshot
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] snap_reg;
  wire          at_max = &count_reg;

  // restart on load keeps an event of the load cycle in the new interval
  assign count_next = load ? {{(W-1){1'b0}}, event_in} :           // see R12
                      (event_in && !at_max) ? count_reg + 1'b1 : count_reg;

  // accumulator and snapshot
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
      snap_reg  <= '0;
    end else begin
      count_reg <= count_next;
      if (load) begin
        snap_reg <= count_reg;                                      // see R12
      end
    end
  end

  assign snapshot = snap_reg;

  // snapshot takes exactly the count before the load
  property p_load_copies;
    @(posedge clk_sys) disable iff (!rst_b)
    load |=> snap_reg == $past(count_reg);
  endproperty
  a_load_copies: assert property (p_load_copies)                    // see R12
    else $error("snapshot differs from accumulator at load");

  // accumulator restarts from zero or one
  property p_restart;
    @(posedge clk_sys) disable iff (!rst_b)
    load |=> count_reg == {{(W-1){1'b0}}, $past(event_in)};
  endproperty
  a_restart: assert property (p_restart)                            // see R12
    else $error("accumulator did not restart on load");

  // snapshot holds between loads
  property p_snap_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    !load |=> $stable(snap_reg);
  endproperty
  a_snap_hold: assert property (p_snap_hold)                        // see R1
    else $error("snapshot changed without a group load");

endmodule
`default_nettype wire

// [pmc_counters.sv]
// per-link performance monitor counter bank with APB register access
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pmc_counters
  import pmc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // error events from framer and pattern receiver, one-cycle pulses
  input  wire logic        crc6_error_evt,
  input  wire logic        framing_error_evt,
  input  wire logic        alignment_change_evt,
  input  wire logic        sync_loss_evt,
  input  wire logic        pattern_error_evt,
  input  wire logic        line_code_violation_evt,
  input  wire logic        dds_error_evt,
  // timing
  input  wire logic        one_second_tick,
  // status
  output logic             group_update
);

  logic [PMC_CTRL_W-1:0]  ctrl_reg;
  logic [PMC_CTRL_W-1:0]  ctrl_next;
  logic                   update_reg;
  logic                   update_next;
  logic [31:0]            prdata_reg;
  logic                   pslverr_reg;

  logic [PMC_W_CRC-1:0]   crc_snap;
  logic [PMC_W_FER-1:0]   fer_snap;
  logic [PMC_W_ALIGN-1:0] align_snap;
  logic [PMC_W_SYNC-1:0]  sync_snap;
  logic [PMC_W_PAT-1:0]   pat_snap;
  logic [PMC_W_LCV-1:0]   lcv_snap;
  logic [PMC_W_DDS-1:0]   dds_snap;

  // address decode
  wire [3:0]   reg_idx     = paddr[5:2];
  wire         addr_mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (reg_idx <= PMC_IDX_CTRL);
  wire         setup_phase = psel && !penable;
  wire         access_wr   = psel && penable && pwrite && addr_mapped;
  wire         ctrl_wr     = access_wr && (reg_idx == PMC_IDX_CTRL) && pstrb[0];
  wire [1:0]   fmt         = ctrl_reg[PMC_CTRL_FMT_H:PMC_CTRL_FMT_L];
  wire         auto_en     = ctrl_reg[PMC_CTRL_AUTO];
  wire         trig_rise   = ctrl_wr && pwdata[PMC_CTRL_TRIG] && !ctrl_reg[PMC_CTRL_TRIG];

  // format gating of the event sources
  wire         fmt_esf = (fmt == PMC_FMT_ESF);
  wire         fmt_dm  = (fmt == PMC_FMT_DM);
  wire         crc_inc = crc6_error_evt && fmt_esf;                 // see R4
  wire         dds_inc = dds_error_evt && fmt_dm;                   // see R11

  // control register; only the control word is writable
  assign ctrl_next = ctrl_wr ? pwdata[PMC_CTRL_W-1:0] : ctrl_reg;

  // one group load from a trigger edge or from the second tick
  assign update_next = trig_rise || (auto_en && one_second_tick);   // see R2 see R3

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= PMC_CTRL_RESET;
      update_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      update_reg <= update_next;
    end
  end

  assign group_update = update_reg;

  // counters, all loaded by the same pulse
  pmc_event_counter #(.W(PMC_W_CRC)) u_crc (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (crc_inc),
    .load     (update_reg),                                         // see R1
    .snapshot (crc_snap)
  );

  // F bit errors or, in extended superframe, alignment bit errors
  pmc_event_counter #(.W(PMC_W_FER)) u_fer (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (framing_error_evt),                                  // see R5 see R6
    .load     (update_reg),
    .snapshot (fer_snap)
  );

  pmc_event_counter #(.W(PMC_W_ALIGN)) u_align (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (alignment_change_evt),                               // see R7
    .load     (update_reg),
    .snapshot (align_snap)
  );

  pmc_event_counter #(.W(PMC_W_SYNC)) u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (sync_loss_evt),                                      // see R8
    .load     (update_reg),
    .snapshot (sync_snap)
  );

  pmc_event_counter #(.W(PMC_W_PAT)) u_pat (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (pattern_error_evt),                                  // see R9
    .load     (update_reg),
    .snapshot (pat_snap)
  );

  pmc_event_counter #(.W(PMC_W_LCV)) u_lcv (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (line_code_violation_evt),                            // see R10
    .load     (update_reg),
    .snapshot (lcv_snap)
  );

  pmc_event_counter #(.W(PMC_W_DDS)) u_dds (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .event_in (dds_inc),
    .load     (update_reg),
    .snapshot (dds_snap)
  );

  // read mux; unused bits are zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (reg_idx)
      PMC_IDX_CRC_LO: rd_byte = crc_snap[7:0];                     // see R4
      PMC_IDX_CRC_HI: rd_byte = {6'h00, crc_snap[9:8]};
      PMC_IDX_FER_LO: rd_byte = fer_snap[7:0];                     // see R5
      PMC_IDX_FER_HI: rd_byte = {4'h0, fer_snap[11:8]};
      PMC_IDX_ALIGN:  rd_byte = {3'h0, align_snap, 2'h0};          // see R7
      PMC_IDX_SYNC:   rd_byte = {3'h0, sync_snap};                 // see R8
      PMC_IDX_PAT_LO: rd_byte = pat_snap[7:0];                     // see R9
      PMC_IDX_PAT_HI: rd_byte = pat_snap[15:8];
      PMC_IDX_LCV_LO: rd_byte = lcv_snap[7:0];                     // see R10
      PMC_IDX_LCV_HI: rd_byte = lcv_snap[15:8];
      PMC_IDX_DDS_LO: rd_byte = dds_snap[7:0];                     // see R11
      PMC_IDX_DDS_HI: rd_byte = {6'h00, dds_snap[9:8]};
      PMC_IDX_CTRL:   rd_byte = {4'h0, ctrl_reg};
      default:        rd_byte = 8'h00;
    endcase
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= (addr_mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000; // see R13
      pslverr_reg <= !addr_mapped;
    end
  end

  // zero wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = psel && penable && pslverr_reg;

  // a trigger edge produces the load one cycle later
  property p_trig_edge;
    @(posedge clk_sys) disable iff (!rst_b)
    (ctrl_wr && pwdata[PMC_CTRL_TRIG] && !ctrl_reg[PMC_CTRL_TRIG]) |=> group_update;
  endproperty
  a_trig_edge: assert property (p_trig_edge)                        // see R2
    else $error("trigger edge did not load the mapping registers");

  // a second tick with auto update loads the group
  property p_auto_tick;
    @(posedge clk_sys) disable iff (!rst_b)
    (auto_en && one_second_tick) |=> group_update;
  endproperty
  a_auto_tick: assert property (p_auto_tick)                        // see R3
    else $error("second tick did not load the mapping registers");

  // no load without a cause
  property p_no_spurious;
    @(posedge clk_sys) disable iff (!rst_b)
    group_update |-> $past(trig_rise) || $past(auto_en && one_second_tick);
  endproperty
  a_no_spurious: assert property (p_no_spurious)                    // see R1
    else $error("group load without trigger or tick");

  // trigger held at one does not reload
  property p_trig_level;
    @(posedge clk_sys) disable iff (!rst_b)
    (ctrl_wr && ctrl_reg[PMC_CTRL_TRIG] && !auto_en) |=> !group_update;
  endproperty
  a_trig_level: assert property (p_trig_level)                      // see R2
    else $error("trigger without a rising edge loaded the group");

  // CRC counter counts only in extended superframe
  property p_crc_gate;
    @(posedge clk_sys) disable iff (!rst_b)
    (!fmt_esf && !update_reg) |=> $stable(u_crc.count_reg);
  endproperty
  a_crc_gate: assert property (p_crc_gate)                          // see R4
    else $error("crc count moved outside extended superframe");

  // DDS counter counts only in digital-multiplexed format
  property p_dds_gate;
    @(posedge clk_sys) disable iff (!rst_b)
    (!fmt_dm && !update_reg) |=> $stable(u_dds.count_reg);
  endproperty
  a_dds_gate: assert property (p_dds_gate)                          // see R11
    else $error("dds count moved outside dm format");

  // read data upper bits are zero
  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    prdata[31:8] == 24'h00_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)                // see R13
    else $error("reserved read bits not zero");

  // a write to a mapping register leaves the control word alone
  property p_ro_write;
    @(posedge clk_sys) disable iff (!rst_b)
    (access_wr && reg_idx != PMC_IDX_CTRL) |=> $stable(ctrl_reg) && !pslverr;
  endproperty
  a_ro_write: assert property (p_ro_write)                          // see R13
    else $error("write to read-only register had an effect");

  // only a control write may change the control word
  property p_ctrl_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    !ctrl_wr |=> $stable(ctrl_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)                        // see R13
    else $error("control word changed without a control write");

  // a crc error in extended superframe outside a load adds one unless saturated
  property p_crc_count;
    @(posedge clk_sys) disable iff (!rst_b)
    (crc_inc && !update_reg && !(&u_crc.count_reg)) |=> u_crc.count_reg == $past(u_crc.count_reg) + 1'b1;
  endproperty
  a_crc_count: assert property (p_crc_count)                        // see R4
    else $error("crc count did not advance on an error");

  // a framing error outside a load adds one unless saturated
  property p_fer_count;
    @(posedge clk_sys) disable iff (!rst_b)
    (framing_error_evt && !update_reg && !(&u_fer.count_reg)) |=> u_fer.count_reg == $past(u_fer.count_reg) + 1'b1;
  endproperty
  a_fer_count: assert property (p_fer_count)                        // see R5 see R6
    else $error("framing count did not advance on an error");

  // a saturated alignment change count stays at its top until the next load
  property p_align_sat;
    @(posedge clk_sys) disable iff (!rst_b)
    (&u_align.count_reg && !update_reg) |=> &u_align.count_reg;
  endproperty
  a_align_sat: assert property (p_align_sat)                        // see R7
    else $error("alignment change count left saturation without a load");

  // a sync loss outside a load adds one unless saturated
  property p_sync_count;
    @(posedge clk_sys) disable iff (!rst_b)
    (sync_loss_evt && !update_reg && !(&u_sync.count_reg)) |=> u_sync.count_reg == $past(u_sync.count_reg) + 1'b1;
  endproperty
  a_sync_count: assert property (p_sync_count)                      // see R8
    else $error("sync loss count did not advance on an event");

  // a pattern bit error outside a load adds one unless saturated
  property p_pat_count;
    @(posedge clk_sys) disable iff (!rst_b)
    (pattern_error_evt && !update_reg && !(&u_pat.count_reg)) |=> u_pat.count_reg == $past(u_pat.count_reg) + 1'b1;
  endproperty
  a_pat_count: assert property (p_pat_count)                        // see R9
    else $error("pattern error count did not advance on an error");

  // a line code violation outside a load adds one unless saturated
  property p_lcv_count;
    @(posedge clk_sys) disable iff (!rst_b)
    (line_code_violation_evt && !update_reg && !(&u_lcv.count_reg)) |=>
      u_lcv.count_reg == $past(u_lcv.count_reg) + 1'b1;
  endproperty
  a_lcv_count: assert property (p_lcv_count)                        // see R10
    else $error("line code count did not advance on a violation");

  // a dds error in digital-multiplexed format outside a load adds one unless saturated
  property p_dds_count;
    @(posedge clk_sys) disable iff (!rst_b)
    (dds_inc && !update_reg && !(&u_dds.count_reg)) |=> u_dds.count_reg == $past(u_dds.count_reg) + 1'b1;
  endproperty
  a_dds_count: assert property (p_dds_count)                        // see R11
    else $error("dds count did not advance on an error");

endmodule
`default_nettype wire

// [pmc_event_source.sv]
// behavioural framer and pattern receiver feeding error event pulses
`timescale 1ns/1ps
`default_nettype none
module pmc_event_source (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // burst request
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [6:0]  mask,
  input  wire logic [15:0] num,
  // event pulses and state
  output logic [6:0]       evt,
  output logic             busy
);
  logic [15:0] left_reg;
  logic        gap_reg;

  // one pulse per cycle, or every other cycle when slow
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      left_reg <= 16'h0;
      gap_reg  <= 1'b0;
    end else if (start) begin
      left_reg <= num;
      gap_reg  <= 1'b0;
    end else if (busy && !gap_reg) begin
      left_reg <= left_reg - 16'h1;
      gap_reg  <= slow;
    end else begin
      gap_reg <= 1'b0;
    end
  end

  // pulses only while a burst runs
  assign busy = (left_reg != 16'h0);
  assign evt  = (busy && !gap_reg) ? mask : 7'h0;
endmodule
`default_nettype wire

// [tb.sv]
// self-checking testbench of the performance monitor counter bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        group_update;
  logic        tick;
  logic        ev_start;
  logic        ev_slow;
  logic        ev_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [3:0]  pstrb;
  logic [6:0]  ev_mask;
  logic [6:0]  evt;
  logic [15:0] ev_num;
  logic [31:0] r;
  logic        e;
  int          err_total;
  int          checked;

  pmc_counters uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .crc6_error_evt(evt[0]), .framing_error_evt(evt[1]),
    .alignment_change_evt(evt[2]), .sync_loss_evt(evt[3]), .pattern_error_evt(evt[4]),
    .line_code_violation_evt(evt[5]), .dds_error_evt(evt[6]), .one_second_tick(tick),
    .group_update(group_update)
  );

  pmc_event_source src (
    .clk_sys(clk_sys), .rst_b(rst_b), .start(ev_start), .slow(ev_slow), .mask(ev_mask),
    .num(ev_num), .evt(evt), .busy(ev_busy)
  );

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, answer taken at the edge pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd_data, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 50) err_total++;
    rd_data = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] i, input logic [31:0] exp);
    logic [31:0] v;
    logic        x;
    apb(1'b0, {6'h0, i, 2'h0}, 32'h0, v, x);
    chk(v, exp);
    chk({31'h0, x}, 32'h0);
  endtask

  function automatic logic [31:0] sat(input int n, input int w);
    return (n >= (1 << w)) ? (1 << w) - 1 : n;
  endfunction

  // read every mapping register against expected counts
  task automatic check_all(input int c, input int f, input int a, input int s,
                           input int p, input int l, input int d);
    rd(4'h0, sat(c, 10) & 32'hFF);
    rd(4'h1, sat(c, 10) >> 8);
    rd(4'h2, sat(f, 12) & 32'hFF);
    rd(4'h3, sat(f, 12) >> 8);
    rd(4'h4, sat(a, 3) << 2);
    rd(4'h5, sat(s, 5));
    rd(4'h6, sat(p, 16) & 32'hFF);
    rd(4'h7, sat(p, 16) >> 8);
    rd(4'h8, sat(l, 16) & 32'hFF);
    rd(4'h9, sat(l, 16) >> 8);
    rd(4'hA, sat(d, 10) & 32'hFF);
    rd(4'hB, sat(d, 10) >> 8);
  endtask

  // trigger rise, one load pulse, trigger cleared again
  task automatic snap(input logic [3:0] c);
    apb(1'b1, 12'h030, {28'h0, c | 4'h2}, r, e);
    #1;
    chk({31'h0, group_update}, 32'h1);
    @(posedge clk_sys);
    #1;
    chk({31'h0, group_update}, 32'h0);
    apb(1'b1, 12'h030, {28'h0, c & 4'hD}, r, e);
  endtask

  // burst of events on the selected sources, waits for the end
  task automatic burst(input logic [6:0] m, input logic [15:0] n, input logic s);
    int k;
    k = 0;
    @(posedge clk_sys);
    ev_mask  <= m;
    ev_num   <= n;
    ev_slow  <= s;
    ev_start <= 1'b1;
    @(posedge clk_sys);
    ev_start <= 1'b0;
    @(posedge clk_sys);
    #1;
    while (ev_busy === 1'b1 && k < 2000) begin
      k++;
      @(posedge clk_sys);
      #1;
    end
    if (k >= 2000) err_total++;
  endtask

  task automatic pulse_tick;
    @(posedge clk_sys);
    tick <= 1'b1;
    @(posedge clk_sys);
    tick <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 13; i++) rd(i[3:0], 32'h0);
    apb(1'b1, 12'h000, 32'hFF, r, e);
    rd(4'h0, 32'h0);
    apb(1'b0, 12'h034, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_trigger;
    apb(1'b1, 12'h030, 32'h4, r, e);
    burst(7'h7F, 16'd5, 1'b0);
    snap(4'h4);
    check_all(5, 5, 5, 5, 5, 5, 0);
    snap(4'h4);
    check_all(0, 0, 0, 0, 0, 0, 0);
    $display("test trigger done");
  endtask

  task automatic t_dm;
    apb(1'b1, 12'h030, 32'h8, r, e);
    burst(7'h7F, 16'd300, 1'b1);
    snap(4'h8);
    check_all(0, 300, 300, 300, 300, 300, 300);
    $display("test dm done");
  endtask

  task automatic t_auto;
    apb(1'b1, 12'h030, 32'h0, r, e);
    burst(7'h7F, 16'd3, 1'b0);
    pulse_tick;
    chk({31'h0, group_update}, 32'h0);
    apb(1'b1, 12'h030, 32'h1, r, e);
    pulse_tick;
    chk({31'h0, group_update}, 32'h1);
    check_all(0, 3, 3, 3, 3, 3, 0);
    $display("test auto done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    err_total = 0;
    checked   = 0;
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h0;
    pwdata    = 32'h0;
    pstrb     = 4'hF;
    tick      = 1'b0;
    ev_start  = 1'b0;
    ev_slow   = 1'b0;
    ev_mask   = 7'h0;
    ev_num    = 16'h0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset;
    t_trigger;
    t_dm;
    t_auto;
    tally_and_finish;
  end

  // watchdog against a hang
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
